// ===== core/eight_bit_timer_two_compare.sv
// Eight-bit timer/counter with two compare units, flags and masks.
// Assumes a prescaler tick from core logic and an asynchronous external count pin.
// Behaviour
// - Counter and both compare registers are eight bits, processor reachable.
// - Zero is bottom, 255 is the fixed maximum.
// - Top is maximum or compare A, chosen by mode.
// - Three-bit clock select; zero stops the counter.
// - Tick comes from prescaler or chosen edge of the external pin.
// - Each tick clears, increments or decrements per three-bit wave mode.
// - Counter readable and writable at any time.
// - Processor counter write beats clear or count.
// - Overflow flag set at mode-dependent points, can request interrupt.
// - Eight-bit comparator matches counter against both compare registers.
// - Compare flag sets on the tick following the match.
// - Enabled set flag requests interrupt; servicing clears it.
// - Writing one to a flag bit clears it.
// - Flags visible in flag register, each gated by a mask bit.
// - Compare registers double buffered in PWM modes only.
// - Buffered value copied to active register at top or bottom.
// - Processor compare access reaches buffer or active register.
// - Force strobe acts like a match on the output in non-PWM modes.
// - Forced compare sets no flag and leaves the counter alone.
// - Counter write blocks compare matches in the next tick.
// - Outputs driven from match, mode and output mode field.
// - Power-off bit holds the timer disabled.
// - Mode zero counts up, wraps, sets overflow on reaching zero.
// - Mode two clears counter on compare A match.
// - Fast PWM top is 255 in mode 3, compare A in mode 7.
// - Output mode zero takes no action at a match outside fast PWM, where a match drives the output low.
`timescale 1ns/1ps
module eight_bit_timer_two_compare
(
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic clk_en_i,
	input wire logic timer_power_off_i,
	input wire logic prescale_tick_i,
	input wire logic ext_count_pin_i,
	input wire logic [2:0] clock_select_i,
	input wire logic [2:0] wave_mode_i,
	input wire logic [1:0] compare_output_mode_a_i,
	input wire logic [1:0] compare_output_mode_b_i,
	input wire logic force_compare_strobe_a_i,
	input wire logic force_compare_strobe_b_i,
	input wire logic count_wr_i,
	input wire logic [7:0] count_wdata_i,
	input wire logic compare_a_wr_i,
	input wire logic compare_b_wr_i,
	input wire logic [7:0] compare_wdata_i,
	input wire logic [2:0] irq_flag_clear_i,
	input wire logic [2:0] irq_ack_i,
	input wire logic [2:0] irq_mask_reg_i,
	output logic [7:0] count_value_o,
	output logic [7:0] compare_value_a_o,
	output logic [7:0] compare_value_b_o,
	output logic [2:0] irq_flag_reg_o,
	output logic [2:0] irq_req_o,
	output logic wave_out_a_o,
	output logic wave_out_b_o
);
	typedef struct packed {
		logic pin_meta;
		logic pin_sync;
		logic pin_last;
		logic [7:0] count;
		logic count_down;
		logic block_match;
		logic [7:0] ocr_a;
		logic [7:0] ocr_b;
		logic [7:0] buf_a;
		logic [7:0] buf_b;
		logic [2:0] flags;
		logic [2:0] irq;
		logic [1:0] wave;
	} state_type;

	state_type cur;
	state_type nxt;

	function automatic logic is_pwm(input logic [2:0] m);
		is_pwm = (m != timer8_pkg::wm_normal) && (m != timer8_pkg::wm_ctc);
	endfunction

	function automatic logic apply_com(input logic [1:0] com, input logic old);
		case (com)
			timer8_pkg::com_toggle: apply_com = ~old;
			timer8_pkg::com_clear: apply_com = 1'b0;
			timer8_pkg::com_set: apply_com = 1'b1;
			default: apply_com = old;
		endcase
	endfunction

	logic tick;
	logic ext_edge;
	logic pwm;
	logic fast;
	logic phase;
	logic [7:0] top;
	logic at_top;
	logic at_bottom;
	logic [1:0] match;
	logic [1:0] force_hit;
	logic [1:0] hit;
	logic ovf_event;
	logic [2:0] flag_set;
	logic [7:0] ocr [2];
	logic [1:0] com [2];

	assign ocr[0] = cur.ocr_a;
	assign ocr[1] = cur.ocr_b;
	assign com[0] = compare_output_mode_a_i;
	assign com[1] = compare_output_mode_b_i;
	assign pwm = is_pwm(wave_mode_i);
	assign fast = (wave_mode_i == timer8_pkg::wm_fast_max) || (wave_mode_i == timer8_pkg::wm_fast_ocra);
	assign phase = (wave_mode_i == timer8_pkg::wm_pc_max) || (wave_mode_i == timer8_pkg::wm_pc_ocra);
	// Top is compare A for modes 2, 5 and 7, otherwise the fixed maximum.
	assign top = (wave_mode_i == timer8_pkg::wm_ctc || wave_mode_i == timer8_pkg::wm_pc_ocra
		|| wave_mode_i == timer8_pkg::wm_fast_ocra) ? cur.ocr_a : timer8_pkg::count_max;
	assign at_top = (cur.count == top);
	assign at_bottom = (cur.count == timer8_pkg::count_bottom);
	// Edge detect reads only the second and third stages, never the first.
	assign ext_edge = (clock_select_i == timer8_pkg::cs_ext_rise) ? (cur.pin_sync & ~cur.pin_last)
		: (~cur.pin_sync & cur.pin_last);
	always_comb
	begin
		if (timer_power_off_i || clock_select_i == timer8_pkg::cs_stopped)
			tick = 1'b0;
		else if (clock_select_i == timer8_pkg::cs_ext_fall || clock_select_i == timer8_pkg::cs_ext_rise)
			tick = ext_edge;
		else
			tick = prescale_tick_i;
	end

	genvar u;
	generate
		for (u = 0; u < 2; u++)
		begin : g_cmp
			assign match[u] = (cur.count == ocr[u]) && !cur.block_match;
			assign force_hit[u] = !pwm && (u == 0 ? force_compare_strobe_a_i
				: force_compare_strobe_b_i);
		end
	endgenerate
	assign hit = match & {2{tick}};
	// Every set source is gathered here so that a clear in the same cycle cannot swallow it.
	assign ovf_event = tick && (phase ? (at_bottom && cur.count_down)
		: (cur.count == timer8_pkg::count_max || (fast && at_top)));
	// Bit order follows the flag positions: compare B, compare A, overflow.
	assign flag_set = {hit[1], hit[0], ovf_event};

	always_comb
	begin
		nxt = cur;
		nxt.pin_meta = ext_count_pin_i;
		nxt.pin_sync = cur.pin_meta;
		nxt.pin_last = cur.pin_sync;
		if (tick)
			nxt.block_match = 1'b0;
		// Counter update on a tick.
		if (tick)
		begin
			if (phase)
			begin
				if (at_top)
				begin
					nxt.count_down = 1'b1;
					nxt.count = cur.count - 8'h01;
				end
				else if (at_bottom && cur.count_down)
				begin
					nxt.count_down = 1'b0;
					nxt.count = cur.count + 8'h01;
				end
				else
					nxt.count = cur.count_down ? cur.count - 8'h01 : cur.count + 8'h01;
			end
			else if ((wave_mode_i == timer8_pkg::wm_ctc || fast) && at_top && match[0])
				nxt.count = timer8_pkg::count_bottom;
			else if (fast && at_top)
				nxt.count = timer8_pkg::count_bottom;
			else
				nxt.count = cur.count + 8'h01;
			// Buffered compare values reach the active registers only at the ends.
			if (pwm && ((fast && at_top) || (phase && at_top) || (!fast && !phase && at_bottom)))
			begin
				nxt.ocr_a = cur.buf_a;
				nxt.ocr_b = cur.buf_b;
			end
		end
		if (!pwm)
		begin
			nxt.ocr_a = cur.buf_a;
			nxt.ocr_b = cur.buf_b;
		end
		// Counter write wins over counting and arms the block for the next tick.
		if (count_wr_i)
		begin
			nxt.count = count_wdata_i;
			nxt.block_match = 1'b1;
		end
		if (compare_a_wr_i)
		begin
			nxt.buf_a = compare_wdata_i;
			if (!pwm)
				nxt.ocr_a = compare_wdata_i;
		end
		if (compare_b_wr_i)
		begin
			nxt.buf_b = compare_wdata_i;
			if (!pwm)
				nxt.ocr_b = compare_wdata_i;
		end
		// A set in the same cycle as a clear wins, so an event is never lost.
		nxt.flags = (cur.flags & ~(irq_flag_clear_i | irq_ack_i)) | flag_set;
		nxt.irq = nxt.flags & irq_mask_reg_i;
		for (int k = 0; k < 2; k++)
		begin
			if (pwm && fast && tick)
			begin
				if (hit[k])
					nxt.wave[k] = com[k] == timer8_pkg::com_set;
				else if (at_top && com[k] != timer8_pkg::com_none)
					nxt.wave[k] = com[k] != timer8_pkg::com_set;
			end
			else if (pwm && phase && tick && hit[k] && com[k] != timer8_pkg::com_none)
				nxt.wave[k] = (com[k] == timer8_pkg::com_set) ^ cur.count_down;
			else if (!pwm && (hit[k] || force_hit[k]))
				nxt.wave[k] = apply_com(com[k], cur.wave[k]);
		end
		if (!clk_en_i)
			nxt = cur;
	end

	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cur <= '0;
			cur.count <= timer8_pkg::count_reset;
		end
		else
			cur <= nxt;
	end

	assign count_value_o = cur.count;
	// Outside the PWM modes the active register copies the buffer every cycle, so reading the
	// buffer keeps these outputs straight from flip-flops without a mode multiplexer.
	assign compare_value_a_o = cur.buf_a;
	assign compare_value_b_o = cur.buf_b;
	assign irq_flag_reg_o = cur.flags;
	assign irq_req_o = cur.irq;
	assign wave_out_a_o = cur.wave[0];
	assign wave_out_b_o = cur.wave[1];

	sequence s_cnt_write;
		clk_en_i && count_wr_i;
	endsequence

	AST_WRITE_WINS: assert property (@(posedge core_clk_i) disable iff (reset_i)
		s_cnt_write |=> count_value_o == $past(count_wdata_i))
		else $error("counter write lost");
	AST_STOPPED: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clock_select_i == timer8_pkg::cs_stopped && !count_wr_i && clk_en_i)
		|=> $stable(count_value_o))
		else $error("stopped counter moved");
	AST_POWER_OFF: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(timer_power_off_i && !count_wr_i) |=> $stable(count_value_o))
		else $error("powered off timer counted");
	AST_FLAG_A: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && hit[0]) |=> irq_flag_reg_o[timer8_pkg::flag_a])
		else $error("match flag a not set");
	AST_CLEAR_ONE: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && irq_flag_clear_i[timer8_pkg::flag_b] && !hit[1])
		|=> !irq_flag_reg_o[timer8_pkg::flag_b])
		else $error("flag b not cleared");
	AST_MASK: assert property (@(posedge core_clk_i) disable iff (reset_i)
		irq_req_o == (irq_flag_reg_o & $past(irq_mask_reg_i)) || !$past(clk_en_i))
		else $error("irq not gated by mask");
	AST_BLOCK: assert property (@(posedge core_clk_i) disable iff (reset_i)
		s_cnt_write |=> (match == 2'h0))
		else $error("match after counter write");
	AST_FORCE_NOFLAG: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && force_hit[0] && !tick && !irq_flag_reg_o[timer8_pkg::flag_a])
		|=> !irq_flag_reg_o[timer8_pkg::flag_a])
		else $error("force set a flag");
	AST_WRAP: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && tick && !count_wr_i && wave_mode_i == timer8_pkg::wm_normal
		&& count_value_o == timer8_pkg::count_max)
		|=> count_value_o == timer8_pkg::count_bottom && irq_flag_reg_o[timer8_pkg::flag_ovf])
		else $error("normal wrap wrong");

	// Shared steps: a counting tick that no counter write overrides, and a pending
	// overflow clear from either software or the interrupt acknowledge.
	sequence s_run_tick;
		clk_en_i && tick && !count_wr_i;
	endsequence

	sequence s_ovf_clear;
		irq_flag_clear_i[timer8_pkg::flag_ovf] || irq_ack_i[timer8_pkg::flag_ovf];
	endsequence

	AST_FLAG_B: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && hit[1]) |=> irq_flag_reg_o[timer8_pkg::flag_b])
		else $error("match flag b not set");
	AST_SET_WINS: assert property (@(posedge core_clk_i) disable iff (reset_i)
		s_run_tick ##0 s_ovf_clear ##0 (wave_mode_i == timer8_pkg::wm_normal
		&& count_value_o == timer8_pkg::count_max) |=> irq_flag_reg_o[timer8_pkg::flag_ovf])
		else $error("overflow lost to a clear");
	AST_ACK_CLEARS: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && irq_ack_i[timer8_pkg::flag_b] && !hit[1])
		|=> !irq_flag_reg_o[timer8_pkg::flag_b])
		else $error("serviced flag b not cleared");
	AST_CTC_CLEAR: assert property (@(posedge core_clk_i) disable iff (reset_i)
		s_run_tick ##0 (wave_mode_i == timer8_pkg::wm_ctc && match[0])
		|=> count_value_o == timer8_pkg::count_bottom)
		else $error("clear on match missed");
	AST_FAST_TOP: assert property (@(posedge core_clk_i) disable iff (reset_i)
		s_run_tick ##0 (wave_mode_i == timer8_pkg::wm_fast_max
		&& count_value_o == timer8_pkg::count_max) |=> count_value_o == timer8_pkg::count_bottom)
		else $error("fast mode top wrong");
	AST_FORCE_PWM: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && pwm && !tick && force_compare_strobe_a_i) |=> $stable(wave_out_a_o))
		else $error("force acted in a pwm mode");
	AST_NO_ACTION: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && !pwm && compare_output_mode_b_i == timer8_pkg::com_none)
		|=> $stable(wave_out_b_o))
		else $error("output b moved with no action set");
	AST_DIRECT: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && !pwm && compare_a_wr_i) |=> cur.ocr_a == $past(compare_wdata_i))
		else $error("direct compare write lost");
	AST_BUFFERED: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && pwm && compare_a_wr_i && !tick) |=> $stable(cur.ocr_a))
		else $error("buffered write reached active register");
	AST_TOP_LOAD: assert property (@(posedge core_clk_i) disable iff (reset_i)
		s_run_tick ##0 (fast && at_top) |=> cur.ocr_a == $past(cur.buf_a))
		else $error("buffer not loaded at top");
	AST_PHASE_OVF: assert property (@(posedge core_clk_i) disable iff (reset_i)
		s_run_tick ##0 (phase && at_bottom && cur.count_down) |=> irq_flag_reg_o[timer8_pkg::flag_ovf])
		else $error("phase overflow not set");
	AST_EXT_TICK: assert property (@(posedge core_clk_i) disable iff (reset_i)
		(clk_en_i && !count_wr_i && !timer_power_off_i && clock_select_i == timer8_pkg::cs_ext_rise
		&& wave_mode_i == timer8_pkg::wm_normal && cur.pin_sync && !cur.pin_last)
		|=> count_value_o == $past(count_value_o) + 8'h01)
		else $error("external edge did not count");
endmodule // eight_bit_timer_two_compare

// ===== core/timer8_pkg.sv
// Constants shared by the eight-bit two-compare timer.
// Assumes a single system clock; the prescaler lives outside this block.
package timer8_pkg;
	localparam logic [7:0] count_bottom = 8'h00;
	localparam logic [7:0] count_max = 8'hff;
	localparam logic [7:0] count_reset = 8'h00;
	localparam logic [2:0] cs_stopped = 3'h0;
	localparam logic [2:0] cs_ext_fall = 3'h6;
	localparam logic [2:0] cs_ext_rise = 3'h7;
	localparam logic [2:0] wm_normal = 3'h0;
	localparam logic [2:0] wm_pc_max = 3'h1;
	localparam logic [2:0] wm_ctc = 3'h2;
	localparam logic [2:0] wm_fast_max = 3'h3;
	localparam logic [2:0] wm_pc_ocra = 3'h5;
	localparam logic [2:0] wm_fast_ocra = 3'h7;
	localparam logic [1:0] com_none = 2'h0;
	localparam logic [1:0] com_toggle = 2'h1;
	localparam logic [1:0] com_clear = 2'h2;
	localparam logic [1:0] com_set = 2'h3;
	localparam int flag_ovf = 0;
	localparam int flag_a = 1;
	localparam int flag_b = 2;
endpackage

// ===== verif/eight_bit_timer_two_compare_tb.sv
// Self-checking bench for the eight-bit two-compare timer.
// Assumes registered outputs on core_clk_i; inputs change at the falling edge.
`timescale 1ns/1ps
module eight_bit_timer_two_compare_tb;
	logic core_clk_i, reset_i, clk_en_i, timer_power_off_i, prescale_tick_i, ext_count_pin_i;
	logic [2:0] clock_select_i, wave_mode_i, irq_flag_clear_i, irq_ack_i, irq_mask_reg_i;
	logic [1:0] compare_output_mode_a_i, compare_output_mode_b_i;
	logic force_compare_strobe_a_i, force_compare_strobe_b_i;
	logic count_wr_i, compare_a_wr_i, compare_b_wr_i, wave_out_a_o, wave_out_b_o, w;
	logic [7:0] count_wdata_i, compare_wdata_i, count_value_o, compare_value_a_o;
	logic [7:0] compare_value_b_o, v;
	logic [2:0] irq_flag_reg_o, irq_req_o;
	int fail_count, checks_done, seed, n;
	eight_bit_timer_two_compare dut (.core_clk_i, .reset_i, .clk_en_i, .timer_power_off_i,
		.prescale_tick_i, .ext_count_pin_i, .clock_select_i, .wave_mode_i,
		.compare_output_mode_a_i, .compare_output_mode_b_i, .force_compare_strobe_a_i,
		.force_compare_strobe_b_i, .count_wr_i, .count_wdata_i, .compare_a_wr_i,
		.compare_b_wr_i, .compare_wdata_i, .irq_flag_clear_i, .irq_ack_i, .irq_mask_reg_i,
		.count_value_o, .compare_value_a_o, .compare_value_b_o, .irq_flag_reg_o, .irq_req_o,
		.wave_out_a_o, .wave_out_b_o);
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task idle(input int k);
		repeat (k) @(negedge core_clk_i);
	endtask
	// Ticks are spaced by an idle cycle so the strobe never changes twice in one step.
	task tick(input int k);
		repeat (k)
		begin
			prescale_tick_i = 1'b1;
			idle(1);
			prescale_tick_i = 1'b0;
			idle(1);
		end
	endtask
	task wr_count(input logic [7:0] d);
		count_wdata_i = d;
		count_wr_i = 1'b1;
		idle(1);
		count_wr_i = 1'b0;
		idle(1);
	endtask
	task wr_cmp(input logic [7:0] d, input logic to_b);
		compare_wdata_i = d;
		{compare_a_wr_i, compare_b_wr_i} = {~to_b, to_b};
		idle(1);
		{compare_a_wr_i, compare_b_wr_i} = 2'h0;
		idle(1);
	endtask
	task clr(input logic [2:0] c, input logic [2:0] a);
		irq_flag_clear_i = c;
		irq_ack_i = a;
		idle(1);
		irq_flag_clear_i = 3'h0;
		irq_ack_i = 3'h0;
		idle(1);
	endtask
	function logic [7:0] after(input logic [7:0] s, input int k);
		return s + k[7:0];
	endfunction
	initial
	begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial
	begin
		repeat (20000) @(posedge core_clk_i);
		fail_count++;
		final_report();
	end
	initial
	begin
		{reset_i, clk_en_i, seed} = {1'b1, 1'b1, 32'ha265};
		{timer_power_off_i, prescale_tick_i, ext_count_pin_i, count_wr_i} = 4'h0;
		{clock_select_i, wave_mode_i, irq_flag_clear_i, irq_ack_i, irq_mask_reg_i} = 15'h0;
		{compare_output_mode_a_i, compare_output_mode_b_i} = 4'h0;
		{force_compare_strobe_a_i, force_compare_strobe_b_i, compare_a_wr_i} = 3'h0;
		{compare_b_wr_i, count_wdata_i, compare_wdata_i} = 17'h0;
		repeat (12) @(posedge core_clk_i);
		idle(1);
		reset_i = 1'b0;
		check(count_value_o, 8'h00);
		check({5'h0, irq_flag_reg_o}, 8'h00);
		clock_select_i = 3'h1;
		repeat (8)
		begin
			v = $random(seed);
			n = ($random(seed) & 7) + 1;
			wr_count(v);
			check(count_value_o, v);
			tick(n);
			check(count_value_o, after(v, n));
		end
		$display("random counting done");
		count_wdata_i = 8'h40;
		{count_wr_i, prescale_tick_i} = 2'h3;
		idle(1);
		{count_wr_i, prescale_tick_i} = 2'h0;
		idle(1);
		check(count_value_o, 8'h40);
		clock_select_i = timer8_pkg::cs_stopped;
		tick(3);
		check(count_value_o, 8'h40);
		{clock_select_i, timer_power_off_i} = 4'h3;
		tick(3);
		check(count_value_o, 8'h40);
		{timer_power_off_i, clk_en_i} = 2'h0;
		tick(2);
		clk_en_i = 1'b1;
		check(count_value_o, 8'h40);
		clr(3'h7, 3'h0);
		wr_count(8'hff);
		tick(1);
		idle(2);
		check(count_value_o, 8'h00);
		check({7'h0, irq_flag_reg_o[0]}, 8'h01);
		check({7'h0, irq_req_o[0]}, 8'h00);
		irq_mask_reg_i = 3'h1;
		idle(3);
		check({7'h0, irq_req_o[0]}, 8'h01);
		clr(3'h6, 3'h0);
		check({7'h0, irq_flag_reg_o[0]}, 8'h01);
		clr(3'h0, 3'h1);
		check({7'h0, irq_flag_reg_o[0]}, 8'h00);
		// Overflow and its clear arrive together: the set must survive.
		wr_count(8'hff);
		{prescale_tick_i, irq_flag_clear_i} = 4'h9;
		idle(1);
		{prescale_tick_i, irq_flag_clear_i} = 4'h0;
		idle(1);
		check({7'h0, irq_flag_reg_o[0]}, 8'h01);
		clr(3'h1, 3'h0);
		$display("overflow and flags done");
		wr_cmp(8'h20, 1'b0);
		check(compare_value_a_o, 8'h20);
		wr_cmp(8'h22, 1'b1);
		check(compare_value_b_o, 8'h22);
		wr_count(8'h1e);
		clr(3'h7, 3'h0);
		tick(2);
		check({5'h0, irq_flag_reg_o}, 8'h00);
		tick(1);
		check({5'h0, irq_flag_reg_o}, 8'h02);
		clr(3'h2, 3'h0);
		check({5'h0, irq_flag_reg_o}, 8'h00);
		wr_count(8'h20);
		tick(2);
		check({5'h0, irq_flag_reg_o}, 8'h00);
		check(count_value_o, 8'h22);
		irq_mask_reg_i = 3'h4;
		tick(1);
		check({5'h0, irq_flag_reg_o}, 8'h04);
		check({5'h0, irq_req_o}, 8'h04);
		clr(3'h0, 3'h4);
		check({5'h0, irq_flag_reg_o}, 8'h00);
		$display("compare match done");
		wave_mode_i = timer8_pkg::wm_ctc;
		wr_cmp(8'h03, 1'b0);
		wr_count(8'h00);
		for (int k = 1; k <= 8; k++)
		begin
			tick(1);
			check(count_value_o, after(8'h00, k % 4));
		end
		{clock_select_i, compare_output_mode_a_i} = {timer8_pkg::cs_stopped, timer8_pkg::com_toggle};
		clr(3'h7, 3'h0);
		{w, v} = {wave_out_a_o, count_value_o};
		{force_compare_strobe_a_i, force_compare_strobe_b_i} = 2'h3;
		idle(1);
		{force_compare_strobe_a_i, force_compare_strobe_b_i} = 2'h0;
		idle(2);
		check({7'h0, wave_out_a_o}, {7'h0, ~w});
		check({7'h0, wave_out_b_o}, 8'h00);
		check({5'h0, irq_flag_reg_o}, 8'h00);
		check(count_value_o, v);
		{compare_output_mode_a_i, compare_output_mode_b_i} = {timer8_pkg::com_clear, timer8_pkg::com_set};
		{force_compare_strobe_a_i, force_compare_strobe_b_i} = 2'h3;
		idle(1);
		{force_compare_strobe_a_i, force_compare_strobe_b_i} = 2'h0;
		idle(2);
		check({7'h0, wave_out_a_o}, 8'h00);
		check({7'h0, wave_out_b_o}, 8'h01);
		$display("ctc and force done");
		// Fast modes ignore the strobe; the buffered top loads at the top of the count.
		wave_mode_i = timer8_pkg::wm_fast_max;
		w = wave_out_a_o;
		force_compare_strobe_a_i = 1'b1;
		idle(1);
		force_compare_strobe_a_i = 1'b0;
		idle(2);
		check({7'h0, wave_out_a_o}, {7'h0, w});
		wr_cmp(8'h55, 1'b0);
		check(compare_value_a_o, 8'h55);
		clock_select_i = 3'h1;
		wr_count(8'hfe);
		tick(2);
		check(count_value_o, 8'h00);
		check({6'h0, wave_out_a_o, wave_out_b_o}, 8'h02);
		wave_mode_i = timer8_pkg::wm_fast_ocra;
		wr_count(8'h54);
		tick(2);
		check(count_value_o, 8'h00);
		check({6'h0, wave_out_a_o, wave_out_b_o}, 8'h00);
		$display("pwm top done");
		{wave_mode_i, clock_select_i} = {timer8_pkg::wm_normal, timer8_pkg::cs_ext_rise};
		wr_count(8'h10);
		for (int k = 0; k < 4; k++)
		begin
			if (k == 2)
				clock_select_i = timer8_pkg::cs_ext_fall;
			ext_count_pin_i = ~ext_count_pin_i;
			idle(5);
			check(count_value_o, after(8'h11, k / 3));
		end
		$display("external pin done");
		// Phase correct with top from compare A: the new top only lands at the old top.
		{wave_mode_i, clock_select_i} = {timer8_pkg::wm_pc_ocra, 3'h1};
		wr_cmp(8'h04, 1'b0);
		wr_count(8'h54);
		tick(2);
		check(count_value_o, 8'h54);
		wr_count(8'h02);
		clr(3'h7, 3'h0);
		tick(3);
		check(count_value_o, 8'h01);
		check({7'h0, irq_flag_reg_o[0]}, 8'h01);
		tick(4);
		check(count_value_o, 8'h03);
		wave_mode_i = timer8_pkg::wm_pc_max;
		wr_count(8'h01);
		tick(2);
		wr_count(8'hfe);
		tick(2);
		check(count_value_o, 8'hfe);
		$display("phase correct done");
		final_report();
	end
endmodule // eight_bit_timer_two_compare_tb
